// >>> design/bmfwp_pkg.sv
package bmfwp_pkg;
  localparam int LONG_W         = 36;
  localparam int NARROW_W       = 18;
  localparam int BYTE_W         = 9;
  localparam int OFFSET_W       = 12;
  localparam int NUM_OFFSETS    = 4;
  // Offset load order
  localparam int OFS_FIRST_AF   = 0;
  localparam int OFS_FIRST_AE   = 1;
  localparam int OFS_SECOND_AF  = 2;
  localparam int OFS_SECOND_AE  = 3;
  // Empty flag fall after reset entry, standard mode; fall-through is one less
  localparam int EMPTY_LAT_STD  = 2;
  localparam int EMPTY_LAT_FIRST_WORD_FALLTHROUGH = EMPTY_LAT_STD - 1;
  // Host holds master or partial reset this many cycles
  localparam int RST_HOLD       = 4;
endpackage : bmfwp_pkg

// >>> design/bmfwp_link_if.sv
`timescale 1ns/1ps
interface bmfwp_link_if (
  input wire logic mclk,   // Common clock
  input wire logic reset   // Sync reset, active high
);
  logic                                firstMasterResetN;   // Master reset, FIFO 1
  logic                                secondMasterResetN;  // Master reset, FIFO 2
  logic                                firstPartialResetN;  // Partial reset, FIFO 1
  logic                                secondPartialResetN; // Partial reset, FIFO 2
  logic                                endianFallSelect;    // Endian, then fall-through
  logic                                writeSizeSelect;     // 1 byte, 0 word
  logic                                serialLoadSelect;    // 1 serial offset load
  logic                                writeMailSelect;     // Narrow port mail select
  logic                                writeEnable;         // Narrow port write
  logic [bmfwp_pkg::NARROW_W-1:0]      writeData;           // Narrow port data
  logic                                widePortChipSelectN; // Wide port select
  logic                                widePortWriteRead;   // Wide port write when high
  logic                                widePortMailSelect;  // Wide port mail select
  logic                                widePortEnable;      // Wide port strobe
  logic [bmfwp_pkg::LONG_W-1:0]        widePortData;        // Wide port data
  logic                                serialOffsetInput;   // Serial offset bit
  logic                                serialEnable;        // Serial bit strobe
  logic                                widePortFullReady;   // FIFO 1 input ready
  logic                                writePortFullReady;  // FIFO 2 input ready
  logic                                readPortEmptyReady;  // FIFO 1 output ready
  logic                                widePortEmptyReady;  // FIFO 2 output ready

  modport dev (
    input  mclk, reset,
    input  firstMasterResetN, secondMasterResetN, firstPartialResetN, secondPartialResetN,
    input  endianFallSelect, writeSizeSelect, serialLoadSelect, writeMailSelect,
    input  writeEnable, writeData, widePortChipSelectN, widePortWriteRead,
    input  widePortMailSelect, widePortEnable, widePortData, serialOffsetInput, serialEnable,
    output widePortFullReady, writePortFullReady, readPortEmptyReady, widePortEmptyReady
  );
  modport host (
    input  mclk, reset,
    output firstMasterResetN, secondMasterResetN, firstPartialResetN, secondPartialResetN,
    output endianFallSelect, writeSizeSelect, serialLoadSelect, writeMailSelect,
    output writeEnable, writeData, widePortChipSelectN, widePortWriteRead,
    output widePortMailSelect, widePortEnable, widePortData, serialOffsetInput, serialEnable,
    input  widePortFullReady, writePortFullReady, readPortEmptyReady, widePortEmptyReady
  );
endinterface : bmfwp_link_if

// >>> design/bmfwp_packer.sv
`timescale 1ns/1ps
module bmfwp_packer #(
  parameter int LONG_W   = bmfwp_pkg::LONG_W,
  parameter int NARROW_W = bmfwp_pkg::NARROW_W,
  parameter int BYTE_W   = bmfwp_pkg::BYTE_W
) (
  input  wire logic                mclk,       // Clock
  input  wire logic                reset,      // Sync reset
  input  wire logic                clear,      // Drop partial long word
  input  wire logic                take,       // Accept one narrow write
  input  wire logic                byteSize,   // 1 byte, 0 word
  input  wire logic                bigEndian,  // Most significant first
  input  wire logic [NARROW_W-1:0] narrowData, // Narrow write data
  output logic                     commit,     // Long word complete, one cycle
  output logic [LONG_W-1:0]        longWord    // Assembled long word
);
  logic [1:0]        countQ, countD;
  logic [LONG_W-1:0] holdQ, holdD, merged, wordD;
  logic              commitD;
  logic              last;
  logic [1:0]        lane;

  always_comb begin
    merged = holdQ;
    lane   = 2'h0;
    last   = 1'b0;
    if (byteSize) begin
      // Upper narrow lines ignored in byte size
      // all four lanes, one per write
      lane = bigEndian ? 2'(2'h3 - countQ) : countQ;
      merged[lane*BYTE_W +: BYTE_W] = narrowData[BYTE_W-1:0];
      last = (countQ == 2'h3);
    end else begin
      lane = bigEndian ? {1'b0, ~countQ[0]} : {1'b0, countQ[0]};
      merged[lane*NARROW_W +: NARROW_W] = narrowData;
      last = countQ[0];
    end
    countD  = countQ;
    holdD   = holdQ;
    commitD = 1'b0;
    wordD   = longWord;
    if (clear) begin
      countD = 2'h0;
      holdD  = '0;
    end else if (take) begin
      holdD = merged;
      if (last) begin
        countD  = 2'h0;
        holdD   = '0;
        commitD = 1'b1;
        wordD   = merged;
      end else begin
        countD = 2'(countQ + 2'h1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      countQ   <= 2'h0;
      holdQ    <= '0;
      commit   <= 1'b0;
      longWord <= '0;
    end else begin
      countQ   <= countD;
      holdQ    <= holdD;
      commit   <= commitD;
      longWord <= wordD;
    end
  end
endmodule : bmfwp_packer

// >>> design/bmfwp_device.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - Memory gets only whole 36-bit long words
// - Earlier narrow parts held until long complete
// - Last narrow write also commits long word
// - Byte size ignores upper nine data lines
// - Host holds partial1, mail high in reset
// - Host holds partial2, mail high in reset
// - Fall-through in partial, big endian in master reset: read empty flag falls earlier
// - Fall-through in partial, big endian in master reset: wide empty flag falls earlier
// - Host toggles both master resets together
// - Master1 stays high during partial1 reset
// - Master2 stays high during partial2 reset
// - Full flags rise cycle after last load
// - Parallel load: select low, write, mail low
// - Offset loads may have idle gaps
// - Writes ignored until both full flags high
// - Serial order: AF1, AE1, AF2, AE2
// - Endian latched at master reset release
// - Big endian sends most significant first
// - Narrow port is word or byte sized
module bmfwp_device #(
  parameter int OFFSET_W = bmfwp_pkg::OFFSET_W
) (
  bmfwp_link_if.dev                     link,             // Link to host
  output logic                          memWrite,         // FIFO 2 memory write
  output logic [bmfwp_pkg::LONG_W-1:0]  memData,          // FIFO 2 long word
  input  wire logic                     memFull,          // FIFO 2 memory full
  input  wire logic                     firstNotEmpty,    // FIFO 1 holds data
  input  wire logic                     secondNotEmpty,   // FIFO 2 holds data
  output logic [bmfwp_pkg::NUM_OFFSETS-1:0][OFFSET_W-1:0] offsets, // Loaded offsets
  output logic                          bigEndian,        // Latched endian
  output logic                          fallThrough,      // Latched fall-through
  output logic                          byteSize          // Latched size
);
  typedef enum logic [1:0] {DV_RESET, DV_LOAD, DV_RUN} bmfwp_dstate_e;

  localparam int BIT_W = $clog2(OFFSET_W);

  // Clock and reset come in over the link
  logic          mclk;
  logic          reset;
  assign mclk  = link.mclk;
  assign reset = link.reset;

  bmfwp_dstate_e stateQ, stateD;
  logic [1:0]    idxQ, idxD;
  logic [BIT_W-1:0] bitQ, bitD;
  logic [bmfwp_pkg::NUM_OFFSETS-1:0][OFFSET_W-1:0] offsetsD;
  logic          masterPrevQ, riseDlyQ, riseDlyD;
  logic          bigEndianD, fallThroughD, byteSizeD;
  logic          wideFullQ, wideFullD, writeFullQ, writeFullD;
  logic [1:0]    emptyQ, emptyD;
  logic [1:0]    rstCntQ [2];
  logic [1:0]    rstCntD [2];
  logic          masterLow, masterRise;
  logic [1:0]    resetting, notEmpty;
  logic [1:0]    emptyLat;
  logic          parallelLoad, serialLoad, lastLoad, writeTake;

  assign masterLow  = ~link.firstMasterResetN | ~link.secondMasterResetN;
  assign masterRise = ~masterPrevQ & ~masterLow;
  assign resetting  = {masterLow | ~link.secondPartialResetN,
                       masterLow | ~link.firstPartialResetN};
  assign notEmpty   = {secondNotEmpty, firstNotEmpty};
  assign emptyLat   = link.endianFallSelect ? 2'(bmfwp_pkg::EMPTY_LAT_FIRST_WORD_FALLTHROUGH)
                                            : 2'(bmfwp_pkg::EMPTY_LAT_STD);

  assign parallelLoad = (stateQ == DV_LOAD) & ~link.serialLoadSelect &
                        ~link.widePortChipSelectN & link.widePortWriteRead &
                        ~link.widePortMailSelect & link.widePortEnable;
  assign serialLoad   = (stateQ == DV_LOAD) & link.serialLoadSelect & link.serialEnable;
  assign lastLoad     = (idxQ == 2'(bmfwp_pkg::NUM_OFFSETS - 1)) &
                        (parallelLoad | (serialLoad & (bitQ == BIT_W'(OFFSET_W - 1))));

  assign writeTake = (stateQ == DV_RUN) & wideFullQ & writeFullQ & link.writeEnable &
                     ~link.writeMailSelect & ~resetting[1];

  always_comb begin
    stateD       = stateQ;
    idxD         = idxQ;
    bitD         = bitQ;
    offsetsD     = offsets;
    bigEndianD   = bigEndian;
    fallThroughD = fallThrough;
    byteSizeD    = byteSize;
    riseDlyD     = masterRise;
    case (stateQ)
      DV_RESET: begin
        idxD = 2'h0;
        bitD = '0;
        if (masterRise) begin
          bigEndianD = link.endianFallSelect;
          byteSizeD  = link.writeSizeSelect;
          stateD     = DV_LOAD;
        end
      end
      DV_LOAD: begin
        // Pin now carries the mode choice
        if (riseDlyQ) begin
          fallThroughD = link.endianFallSelect;
        end
        if (parallelLoad) begin
          offsetsD[idxQ] = link.widePortData[OFFSET_W-1:0];
          idxD           = 2'(idxQ + 2'h1);
        end else if (serialLoad) begin
          offsetsD[idxQ] = {offsets[idxQ][OFFSET_W-2:0], link.serialOffsetInput};
          if (bitQ == BIT_W'(OFFSET_W - 1)) begin
            bitD = '0;
            idxD = 2'(idxQ + 2'h1);
          end else begin
            bitD = BIT_W'(bitQ + 1'b1);
          end
        end
        if (lastLoad) begin
          stateD = DV_RUN;
        end
      end
      DV_RUN: begin
      end
      default: begin
        stateD = DV_RESET;
      end
    endcase
    // Master reset wins over any state
    if (masterLow) begin
      stateD = DV_RESET;
    end
  end

  // Full flags derive from the state register, so they trail the last load by one edge
  always_comb begin
    wideFullD  = (stateQ == DV_RUN) & ~resetting[0];
    writeFullD = (stateQ == DV_RUN) & ~resetting[1] & ~memFull;
    for (int f = 0; f < 2; f++) begin
      rstCntD[f] = rstCntQ[f];
      emptyD[f]  = emptyQ[f];
      if (resetting[f]) begin
        if (rstCntQ[f] >= emptyLat) begin
          emptyD[f] = 1'b0;
        end else begin
          rstCntD[f] = 2'(rstCntQ[f] + 2'h1);
        end
      end else begin
        rstCntD[f] = 2'h0;
        emptyD[f]  = (stateQ == DV_RUN) & notEmpty[f];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      stateQ      <= DV_RESET;
      idxQ        <= 2'h0;
      bitQ        <= '0;
      offsets     <= '0;
      masterPrevQ <= 1'b0;
      riseDlyQ    <= 1'b0;
      bigEndian   <= 1'b0;
      fallThrough <= 1'b0;
      byteSize    <= 1'b0;
      wideFullQ   <= 1'b0;
      writeFullQ  <= 1'b0;
      emptyQ      <= 2'h0;
      rstCntQ[0]  <= 2'h0;
      rstCntQ[1]  <= 2'h0;
    end else begin
      stateQ      <= stateD;
      idxQ        <= idxD;
      bitQ        <= bitD;
      offsets     <= offsetsD;
      masterPrevQ <= ~masterLow;
      riseDlyQ    <= riseDlyD;
      bigEndian   <= bigEndianD;
      fallThrough <= fallThroughD;
      byteSize    <= byteSizeD;
      wideFullQ   <= wideFullD;
      writeFullQ  <= writeFullD;
      emptyQ      <= emptyD;
      rstCntQ     <= rstCntD;
    end
  end

  assign link.widePortFullReady  = wideFullQ;
  assign link.writePortFullReady = writeFullQ;
  assign link.readPortEmptyReady = emptyQ[0];
  assign link.widePortEmptyReady = emptyQ[1];

  bmfwp_packer u_packer (
    .mclk       (mclk),
    .reset      (reset),
    .clear      (resetting[1]),
    .take       (writeTake),
    .byteSize   (byteSize),
    .bigEndian  (bigEndian),
    .narrowData (link.writeData),
    .commit     (memWrite),
    .longWord   (memData)
  );
endmodule : bmfwp_device

// >>> design/bmfwp_host.sv
`timescale 1ns/1ps
module bmfwp_host #(
  parameter int OFFSET_W = bmfwp_pkg::OFFSET_W
) (
  bmfwp_link_if.host                    link,           // Link to device
  input  wire logic                     cfgBigEndian,   // Endian to program
  input  wire logic                     cfgFallThrough, // Fall-through to program
  input  wire logic                     cfgByteSize,    // Narrow port byte size
  input  wire logic                     cfgSerial,      // Serial offset load
  input  wire logic [bmfwp_pkg::NUM_OFFSETS-1:0][OFFSET_W-1:0] cfgOffsets, // Offsets
  input  wire logic                     masterRequest,  // Start master reset, pulse
  input  wire logic [1:0]               partialRequest, // Partial reset per FIFO, pulse
  input  wire logic                     userValid,      // Narrow word offered
  input  wire logic [bmfwp_pkg::NARROW_W-1:0] userData, // Narrow word
  output logic                          userReady,      // Narrow word taken
  output logic                          linkReady       // Device ready for data
);
  typedef enum logic [2:0] {H_MRST, H_LOAD, H_WAIT, H_RUN, H_PRST} bmfwp_hstate_e;

  localparam int BIT_W = $clog2(OFFSET_W);

  bmfwp_hstate_e stateQ, stateD;
  logic [2:0]       cntQ, cntD;
  logic [1:0]       idxQ, idxD, prsSelQ, prsSelD;
  logic [BIT_W-1:0] bitQ, bitD;
  logic             firstQ, firstD;
  logic             mrsD, mailD, endD, wenD, penD, senD, sbitD;
  logic [1:0]       prsD;
  logic [bmfwp_pkg::NARROW_W-1:0] wdatD;
  logic [bmfwp_pkg::LONG_W-1:0]   pdatD;

  assign linkReady = (stateQ == H_RUN);
  assign userReady = (stateQ == H_RUN) & link.writePortFullReady & link.widePortFullReady;

  always_comb begin
    stateD  = stateQ;
    cntD    = cntQ;
    idxD    = idxQ;
    bitD    = bitQ;
    firstD  = 1'b0;
    prsSelD = prsSelQ;
    mrsD    = 1'b1;
    prsD    = 2'h3;
    mailD   = 1'b1;
    endD    = cfgFallThrough;
    wenD    = 1'b0;
    penD    = 1'b0;
    senD    = 1'b0;
    sbitD   = 1'b0;
    pdatD   = '0;
    wdatD   = link.writeData;
    case (stateQ)
      H_MRST: begin
        mrsD = 1'b0;
        endD = cfgBigEndian;
        cntD = 3'(cntQ + 3'h1);
        if (cntQ == 3'(bmfwp_pkg::RST_HOLD - 1)) begin
          cntD   = 3'h0;
          idxD   = 2'h0;
          bitD   = '0;
          firstD = 1'b1;
          stateD = H_LOAD;
        end
      end
      H_LOAD: begin
        if (firstQ) begin
          endD = cfgBigEndian;
        end else if (cfgSerial) begin
          senD  = 1'b1;
          sbitD = cfgOffsets[idxQ][BIT_W'(OFFSET_W - 1) - bitQ];
          bitD  = BIT_W'(bitQ + 1'b1);
          if (bitQ == BIT_W'(OFFSET_W - 1)) begin
            bitD = '0;
            idxD = 2'(idxQ + 2'h1);
          end
        end else begin
          penD  = 1'b1;
          pdatD = bmfwp_pkg::LONG_W'(cfgOffsets[idxQ]);
          idxD  = 2'(idxQ + 2'h1);
        end
        if (~firstQ & (idxD == 2'h0) & (idxQ == 2'h3)) begin
          stateD = H_WAIT;
        end
      end
      H_WAIT: begin
        if (link.widePortFullReady & link.writePortFullReady) begin
          stateD = H_RUN;
        end
      end
      H_RUN: begin
        mailD = 1'b0;
        wenD  = userValid & userReady;
        wdatD = userData;
        if (partialRequest != 2'h0) begin
          prsSelD = partialRequest;
          stateD  = H_PRST;
        end
      end
      H_PRST: begin
        mailD = 1'b0;
        prsD  = ~prsSelQ;
        cntD  = 3'(cntQ + 3'h1);
        if (cntQ == 3'(bmfwp_pkg::RST_HOLD - 1)) begin
          cntD   = 3'h0;
          stateD = H_WAIT;
        end
      end
      default: begin
        stateD = H_MRST;
      end
    endcase
    if (masterRequest) begin
      cntD   = 3'h0;
      stateD = H_MRST;
    end
  end

  always_ff @(posedge link.mclk) begin
    if (link.reset) begin
      stateQ                   <= H_MRST;
      cntQ                     <= 3'h0;
      idxQ                     <= 2'h0;
      bitQ                     <= '0;
      firstQ                   <= 1'b0;
      prsSelQ                  <= 2'h0;
      link.firstMasterResetN   <= 1'b0;
      link.secondMasterResetN  <= 1'b0;
      link.firstPartialResetN  <= 1'b1;
      link.secondPartialResetN <= 1'b1;
      link.writeMailSelect     <= 1'b1;
      link.endianFallSelect    <= 1'b0;
      link.writeEnable         <= 1'b0;
      link.writeData           <= '0;
      link.widePortEnable      <= 1'b0;
      link.widePortData        <= '0;
      link.serialEnable        <= 1'b0;
      link.serialOffsetInput   <= 1'b0;
    end else begin
      stateQ                   <= stateD;
      cntQ                     <= cntD;
      idxQ                     <= idxD;
      bitQ                     <= bitD;
      firstQ                   <= firstD;
      prsSelQ                  <= prsSelD;
      link.firstMasterResetN   <= mrsD;
      link.secondMasterResetN  <= mrsD;
      link.firstPartialResetN  <= prsD[0];
      link.secondPartialResetN <= prsD[1];
      link.writeMailSelect     <= mailD;
      link.endianFallSelect    <= endD;
      link.writeEnable         <= wenD;
      link.writeData           <= wdatD;
      link.widePortEnable      <= penD;
      link.widePortData        <= pdatD;
      link.serialEnable        <= senD;
      link.serialOffsetInput   <= sbitD;
    end
  end

  // Static straps and wide-port qualifiers for offset writes
  assign link.writeSizeSelect     = cfgByteSize;
  assign link.serialLoadSelect    = cfgSerial;
  assign link.widePortChipSelectN = 1'b0;
  assign link.widePortWriteRead   = 1'b1;
  assign link.widePortMailSelect  = 1'b0;
endmodule : bmfwp_host

// >>> bench/bmfwp_assertions.sv
`timescale 1ns/1ps
module bmfwp_assertions (
  input wire logic mclk,                // Clock
  input wire logic reset,               // Sync reset
  input wire logic firstMasterResetN,   // Master reset 1
  input wire logic secondMasterResetN,  // Master reset 2
  input wire logic firstPartialResetN,  // Partial reset 1
  input wire logic secondPartialResetN, // Partial reset 2
  input wire logic writeMailSelect,     // Narrow mail select
  input wire logic endianFallSelect,    // Endian or fall-through pin
  input wire logic serialLoadSelect,    // Serial load mode
  input wire logic widePortChipSelectN, // Wide select
  input wire logic widePortWriteRead,   // Wide write
  input wire logic widePortMailSelect,  // Wide mail select
  input wire logic widePortEnable,      // Wide strobe
  input wire logic widePortFullReady,   // FIFO 1 ready
  input wire logic writePortFullReady,  // FIFO 2 ready
  input wire logic readPortEmptyReady,  // FIFO 1 output ready
  input wire logic widePortEmptyReady   // FIFO 2 output ready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_masters_together: assert property (firstMasterResetN == secondMasterResetN)
    else $error("master resets differ");
  a_partial1_held: assert property (!firstMasterResetN |-> firstPartialResetN && writeMailSelect)
    else $error("partial 1 or mail low in master reset");
  a_partial2_held: assert property (!secondMasterResetN |-> secondPartialResetN && writeMailSelect)
    else $error("partial 2 or mail low in master reset");
  a_master1_in_partial: assert property (!firstPartialResetN |-> firstMasterResetN)
    else $error("master 1 low in partial reset");
  a_master2_in_partial: assert property (!secondPartialResetN |-> secondMasterResetN)
    else $error("master 2 low in partial reset");
  a_parallel_load_select: assert property (widePortEnable && !serialLoadSelect |->
    !widePortChipSelectN && widePortWriteRead && !widePortMailSelect)
    else $error("parallel load selects wrong");
  a_flags_low_reset: assert property (!firstMasterResetN [*2] |->
    !widePortFullReady && !writePortFullReady)
    else $error("full flag high in master reset");
  // Pin high during reset: flag must already be low one edge sooner
  a_read_empty_falls: assert property (($fell(firstMasterResetN) || $fell(firstPartialResetN))
    && readPortEmptyReady |-> ##1 readPortEmptyReady
    ##1 (endianFallSelect ^ readPortEmptyReady) ##1 !readPortEmptyReady)
    else $error("read empty flag falls at wrong time");
  a_wide_empty_falls: assert property (($fell(secondMasterResetN) || $fell(secondPartialResetN))
    && widePortEmptyReady |-> ##1 widePortEmptyReady
    ##1 (endianFallSelect ^ widePortEmptyReady) ##1 !widePortEmptyReady)
    else $error("wide empty flag falls at wrong time");
  a_ready_pair_rise: assert property ($rose(writePortFullReady) && firstPartialResetN
    && secondPartialResetN |-> widePortFullReady)
    else $error("full flags rise apart");

  c_ready: cover property ($rose(writePortFullReady));
  c_partial: cover property ($fell(secondPartialResetN));
  c_parallel: cover property (widePortEnable && !serialLoadSelect);
endmodule : bmfwp_assertions

// >>> bench/tb_bus_matching_fifo_write_packer.sv
`timescale 1ns/1ps
module tb_bus_matching_fifo_write_packer;
  logic             mclk = 1'b0;
  logic             reset = 1'b1;
  logic             cfgBigEndian = 1'b0;
  logic             cfgFallThrough = 1'b0;
  logic             cfgByteSize = 1'b0;
  logic             cfgSerial = 1'b0;
  logic [3:0][11:0] cfgOffsets = '0;
  logic             masterRequest = 1'b0;
  logic [1:0]       partialRequest = 2'h0;
  logic             userValid = 1'b0;
  logic [17:0]      userData = 18'h0;
  logic             userReady, linkReady, memWrite, bigEndian, fallThrough, byteSize;
  logic [35:0]      memData;
  logic             firstNotEmpty = 1'b0;
  logic             secondNotEmpty = 1'b0;
  logic [3:0][11:0] offsets;
  int               err_total = 0;
  int               n_checks = 0;
  int               nCommit = 0;

  always #2 mclk = ~mclk;
  always @(posedge mclk) if (memWrite === 1'b1) nCommit <= nCommit + 1;

  bmfwp_link_if link (.mclk(mclk), .reset(reset));
  bmfwp_host u_bmfwp_host (.link(link), .cfgBigEndian(cfgBigEndian),
    .cfgFallThrough(cfgFallThrough), .cfgByteSize(cfgByteSize), .cfgSerial(cfgSerial),
    .cfgOffsets(cfgOffsets), .masterRequest(masterRequest), .partialRequest(partialRequest),
    .userValid(userValid), .userData(userData), .userReady(userReady), .linkReady(linkReady));
  // Memory full tied low: back-pressure is outside this block
  bmfwp_device u_bmfwp_device (.link(link), .memWrite(memWrite), .memData(memData),
    .memFull(1'b0), .firstNotEmpty(firstNotEmpty), .secondNotEmpty(secondNotEmpty),
    .offsets(offsets), .bigEndian(bigEndian), .fallThrough(fallThrough), .byteSize(byteSize));
  bmfwp_assertions u_bmfwp_assertions (.mclk(mclk), .reset(reset),
    .firstMasterResetN(link.firstMasterResetN), .secondMasterResetN(link.secondMasterResetN),
    .firstPartialResetN(link.firstPartialResetN),
    .secondPartialResetN(link.secondPartialResetN), .writeMailSelect(link.writeMailSelect),
    .endianFallSelect(link.endianFallSelect),
    .serialLoadSelect(link.serialLoadSelect), .widePortChipSelectN(link.widePortChipSelectN),
    .widePortWriteRead(link.widePortWriteRead), .widePortMailSelect(link.widePortMailSelect),
    .widePortEnable(link.widePortEnable), .widePortFullReady(link.widePortFullReady),
    .writePortFullReady(link.writePortFullReady),
    .readPortEmptyReady(link.readPortEmptyReady), .widePortEmptyReady(link.widePortEmptyReady));

  task complete_run;
    $display("Checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      $display("CHECK FAILED at %0t: %s", $time, msg);
      err_total++;
    end
  endtask : check

  task limit(input int t);
    if (t >= 100) begin
      check(1'b0, "wait ran out");
      complete_run();
    end
  endtask : limit

  task wait_link;
    int t;
    t = 0;
    repeat (3) @(posedge mclk);
    while (linkReady !== 1'b1 && t < 100) begin
      @(posedge mclk);
      t++;
    end
    limit(t);
  endtask : wait_link

  task configure(input logic be, input logic ft, input logic bs, input logic ser);
    @(posedge mclk);
    masterRequest <= 1'b1;
    {cfgBigEndian, cfgFallThrough, cfgByteSize, cfgSerial} <= {be, ft, bs, ser};
    cfgOffsets <= {12'hc35, 12'h2e8, 12'h71b, {8'h5a, be, ft, bs, ser}};
    @(posedge mclk);
    masterRequest <= 1'b0;
    wait_link();
    check(offsets === cfgOffsets, "offsets");
    check({bigEndian, fallThrough, byteSize} === {be, ft, bs}, "latched mode");
    check({link.widePortFullReady, link.writePortFullReady} === 2'b11, "full flags");
  endtask : configure

  task push(input logic [17:0] u);
    int t;
    t = 0;
    userValid <= 1'b1;
    userData <= u;
    do begin
      @(posedge mclk);
      t++;
    end while (userReady !== 1'b1 && t < 100);
    limit(t);
  endtask : push

  // Upper byte lines carry junk in byte size so a leak shows in memData
  task send_long(input logic [35:0] lw);
    int         n, idx, t, base;
    logic [8:0] lane;
    n = cfgByteSize ? 4 : 2;
    base = nCommit;
    t = 0;
    for (int k = 0; k < n; k++) begin
      idx = cfgBigEndian ? n - 1 - k : k;
      lane = lw[9*idx +: 9];
      push(cfgByteSize ? {~lane, lane} : lw[18*idx +: 18]);
    end
    userValid <= 1'b0;
    while (memWrite !== 1'b1 && t < 100) begin
      @(posedge mclk);
      t++;
    end
    limit(t);
    check(memData === lw, "long word");
    repeat (3) @(posedge mclk);
    check(nCommit == base + 1, "commit count");
  endtask : send_long

  task empty_follow;
    firstNotEmpty <= 1'b1;
    secondNotEmpty <= 1'b1;
    repeat (3) @(posedge mclk);
    check({link.readPortEmptyReady, link.widePortEmptyReady} === 2'b11, "empty flags");
  endtask : empty_follow

  // Half a long word then partial reset of both FIFOs: the half must vanish
  task partial_drop;
    push(18'h2aaaa);
    userValid <= 1'b0;
    partialRequest <= 2'b11;
    @(posedge mclk);
    partialRequest <= 2'b00;
    wait_link();
    send_long(36'h9_8765_4321);
  endtask : partial_drop

  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    wait_link();
    configure(1'b1, 1'b0, 1'b0, 1'b0);
    send_long(36'h1_2345_6789);
    send_long(36'hf_edcb_a987);
    configure(1'b0, 1'b1, 1'b0, 1'b1);
    send_long(36'h3_0c0c_5a5a);
    configure(1'b1, 1'b1, 1'b1, 1'b1);
    send_long(36'h8_1357_9bdf);
    configure(1'b0, 1'b0, 1'b1, 1'b0);
    send_long(36'h7_0246_8ace);
    empty_follow();
    configure(1'b1, 1'b0, 1'b0, 1'b0);
    partial_drop();
    complete_run();
  end
endmodule : tb_bus_matching_fifo_write_packer
